// [logic/mmc_core_memory_map.sv]
//
// Contract
// - program and data spaces are separate 64KB spaces; fetch uses program space only.
// - flash is read-only except during programming, when it may map into data space.
// - 256-byte read/write internal RAM that also holds the stack.
// - special function space 80h-FFh reached only by direct or bit addressing, never indirectly.
// - accumulator and multiply partner form one 16-bit pair, partner high.
// - stack pointer increments first, then data is written at new value.
// - reset loads stack pointer with 07h so first push lands at 08h.
// - reset clears instruction pointer so first fetch comes from 0000h.
// - taken interrupt jumps to fixed vector, eight bytes apart from 0003h.
// - RAM 0-31 holds four banks of eight registers, bank chosen by flags.
// - RAM bytes 32-47 also reachable as 128 single bits.
// - carry flag takes ALU carry or inverted borrow, also shifts and rotates.
// - half carry flag set on carry from bit 3 or no borrow bit 4.
// - sign range flag set when signed result leaves -128 to +127.
// - parity flag keeps ones count of accumulator plus flag even.
// - 16-bit data pointer of high and low bytes addresses external data.
// - display ram answers external data FF00-FFFF via pointer or register moves.
// - display ram also reached by pointer and buffer; pointer post-increments.
// - disabled display ram stops decoding FF00-FFFF, passing it outward.
// - special registers at addresses ending 0h or 8h are bit addressable.
// - page register extends flash addressing beyond 64K.
`timescale 1ns/10ps
module mmc_core_memory_map
  import mmc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire mmc_byte_req_t direct_req_i,
  input wire mmc_byte_req_t indirect_req_i,
  input wire mmc_reg_req_t reg_req_i,
  input wire mmc_bit_req_t bit_req_i,
  input wire mmc_stack_req_t stack_req_i,
  input wire mmc_xdata_req_t xdata_req_i,
  input wire mmc_alu_upd_t alu_upd_i,
  input wire mmc_pc_ctl_t pc_ctl_i,
  input wire logic flash_update_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic [15:0] fetch_addr_o,
  output logic [15:0] acc_b_pair_o,
  output logic [7:0] flags_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [15:0] external_data_pointer_o,
  output mmc_xbus_t xbus_o,
  output logic [7:0] flash_page_o,
  output logic flash_write_en_o,
  output logic flash_in_data_o
);

  typedef struct packed {
    logic [IRAM_BYTES-1:0][7:0] iram;
    logic [DRAM_BYTES-1:0][7:0] dram;
    logic [7:0] accumulator_reg;
    logic [7:0] multiply_partner_reg;
    logic [7:0] stack_top_pointer;
    logic [7:0] processor_flags_word;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] display_ram_pointer;
    logic [7:0] display_ram_io_buffer;
    logic [7:0] flash_page;
    logic dram_en;
    logic [15:0] instruction_pointer;
    logic [7:0] rd_data;
    logic rd_valid;
    mmc_xbus_t xbus;
    logic flash_write_en;
    logic flash_in_data;
    logic flash_sync_a;
    logic flash_sync_b;
  } mmc_state_t;

  mmc_state_t s;
  mmc_state_t next_s;

  function automatic logic [7:0] sfr_read(input mmc_state_t st, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SFR_ACC: v = st.accumulator_reg;
      SFR_B: v = st.multiply_partner_reg;
      SFR_SP: v = st.stack_top_pointer;
      SFR_PSW: v = st.processor_flags_word;
      SFR_DPL: v = st.data_pointer_low;
      SFR_DPH: v = st.data_pointer_high;
      SFR_DRAM_PTR: v = st.display_ram_pointer;
      SFR_DRAM_BUF: v = st.dram[st.display_ram_pointer];
      SFR_FLASH_PAGE: v = st.flash_page;
      SFR_DRAM_CTL: v = {7'h00, st.dram_en};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : sfr_read

  logic ram_we;
  logic [7:0] ram_a;
  logic [7:0] ram_d;
  logic sfr_we;
  logic [7:0] sfr_a;
  logic [7:0] sfr_d;
  logic dram_we;
  logic [7:0] dram_a;
  logic [7:0] dram_d;
  logic ptr_inc;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] bank_addr;
  logic [7:0] bit_byte;
  logic [7:0] bit_old;
  logic [7:0] bit_new;
  logic [7:0] sp_up;
  logic [15:0] xaddr;
  logic xhit;
  logic [15:0] external_data_pointer_now;

  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.xbus.valid = 1'b0;
    ram_we = 1'b0;
    ram_a = 8'h00;
    ram_d = 8'h00;
    sfr_we = 1'b0;
    sfr_a = 8'h00;
    sfr_d = 8'h00;
    dram_we = 1'b0;
    dram_a = 8'h00;
    dram_d = 8'h00;
    ptr_inc = 1'b0;
    rdata = 8'h00;
    rvalid = 1'b0;
    // bank times eight plus index
    bank_addr = {3'b000, s.processor_flags_word[PSW_RS1], s.processor_flags_word[PSW_RS0],
      reg_req_i.idx};
    // bit address to byte: low half in RAM bit area, high half in SFRs ending 0h/8h
    bit_byte = bit_req_i.addr[7] ? {bit_req_i.addr[7:3], 3'b000} :
      8'(BIT_AREA_BASE + {4'h0, bit_req_i.addr[6:3]});
    bit_old = bit_req_i.addr[7] ? sfr_read(s, bit_byte) : s.iram[bit_byte];
    bit_new = bit_old;
    bit_new[bit_req_i.addr[2:0]] = bit_req_i.wbit;
    sp_up = 8'(s.stack_top_pointer + 8'h01);
    external_data_pointer_now = {s.data_pointer_high, s.data_pointer_low};
    xaddr = xdata_req_i.use_external_data_pointer ? external_data_pointer_now : {xdata_req_i.high, xdata_req_i.low};
    xhit = s.dram_en && (xaddr[15:8] == DRAM_PAGE);

    if (direct_req_i.valid) begin
      if (direct_req_i.addr >= SFR_BASE) begin
        if (direct_req_i.write) begin
          sfr_we = 1'b1;
          sfr_a = direct_req_i.addr;
          sfr_d = direct_req_i.wdata;
        end else begin
          rdata = sfr_read(s, direct_req_i.addr);
          rvalid = 1'b1;
          if (direct_req_i.addr == SFR_DRAM_BUF) begin
            next_s.display_ram_io_buffer = s.dram[s.display_ram_pointer];
            ptr_inc = 1'b1;
          end
        end
      end else if (direct_req_i.write) begin
        ram_we = 1'b1;
        ram_a = direct_req_i.addr;
        ram_d = direct_req_i.wdata;
      end else begin
        rdata = s.iram[direct_req_i.addr];
        rvalid = 1'b1;
      end
    end else if (indirect_req_i.valid) begin
      // indirect always lands in RAM, upper half included
      if (indirect_req_i.write) begin
        ram_we = 1'b1;
        ram_a = indirect_req_i.addr;
        ram_d = indirect_req_i.wdata;
      end else begin
        rdata = s.iram[indirect_req_i.addr];
        rvalid = 1'b1;
      end
    end else if (reg_req_i.valid) begin
      if (reg_req_i.write) begin
        ram_we = 1'b1;
        ram_a = bank_addr;
        ram_d = reg_req_i.wdata;
      end else begin
        rdata = s.iram[bank_addr];
        rvalid = 1'b1;
      end
    end else if (bit_req_i.valid) begin
      if (bit_req_i.write) begin
        if (bit_req_i.addr[7]) begin
          sfr_we = 1'b1;
          sfr_a = bit_byte;
          sfr_d = bit_new;
        end else begin
          ram_we = 1'b1;
          ram_a = bit_byte;
          ram_d = bit_new;
        end
      end else begin
        rdata = {7'h00, bit_old[bit_req_i.addr[2:0]]};
        rvalid = 1'b1;
      end
    end else if (stack_req_i.push) begin
      next_s.stack_top_pointer = sp_up;
      ram_we = 1'b1;
      ram_a = sp_up;
      ram_d = stack_req_i.wdata;
    end else if (stack_req_i.pop) begin
      rdata = s.iram[s.stack_top_pointer];
      rvalid = 1'b1;
      next_s.stack_top_pointer = 8'(s.stack_top_pointer - 8'h01);
    end else if (xdata_req_i.valid) begin
      if (xhit) begin
        if (xdata_req_i.write) begin
          dram_we = 1'b1;
          dram_a = xaddr[7:0];
          dram_d = xdata_req_i.wdata;
        end else begin
          rdata = s.dram[xaddr[7:0]];
          rvalid = 1'b1;
        end
      end else begin
        next_s.xbus.valid = 1'b1;
        next_s.xbus.write = xdata_req_i.write;
        next_s.xbus.addr = xaddr;
        next_s.xbus.wdata = xdata_req_i.wdata;
      end
    end

    if (ram_we) begin
      next_s.iram[ram_a] = ram_d;
    end

    if (sfr_we) begin
      case (sfr_a)
        SFR_ACC: next_s.accumulator_reg = sfr_d;
        SFR_B: next_s.multiply_partner_reg = sfr_d;
        SFR_SP: next_s.stack_top_pointer = sfr_d;
        SFR_PSW: next_s.processor_flags_word = sfr_d;
        SFR_DPL: next_s.data_pointer_low = sfr_d;
        SFR_DPH: next_s.data_pointer_high = sfr_d;
        SFR_DRAM_PTR: next_s.display_ram_pointer = sfr_d;
        SFR_DRAM_BUF: begin
          next_s.display_ram_io_buffer = sfr_d;
          dram_we = 1'b1;
          dram_a = s.display_ram_pointer;
          dram_d = sfr_d;
          ptr_inc = 1'b1;
        end
        SFR_FLASH_PAGE: next_s.flash_page = sfr_d;
        SFR_DRAM_CTL: next_s.dram_en = sfr_d[DRAM_CTL_EN];
        default: next_s.flash_page = next_s.flash_page;
      endcase
    end

    if (dram_we) begin
      next_s.dram[dram_a] = dram_d;
    end
    if (ptr_inc) begin
      next_s.display_ram_pointer = 8'(s.display_ram_pointer + 8'h01);
    end

    // arithmetic unit results win over a same-cycle byte write
    if (alu_upd_i.acc_we) begin
      next_s.accumulator_reg = alu_upd_i.acc;
    end
    if (alu_upd_i.b_we) begin
      next_s.multiply_partner_reg = alu_upd_i.b;
    end
    if (alu_upd_i.cy_we) begin
      next_s.processor_flags_word[PSW_CY] = alu_upd_i.cy;
    end
    if (alu_upd_i.ac_we) begin
      next_s.processor_flags_word[PSW_AC] = alu_upd_i.ac;
    end
    if (alu_upd_i.ov_we) begin
      next_s.processor_flags_word[PSW_OV] = alu_upd_i.ov;
    end
    if (alu_upd_i.external_data_pointer_we) begin
      next_s.data_pointer_high = alu_upd_i.external_data_pointer[15:8];
      next_s.data_pointer_low = alu_upd_i.external_data_pointer[7:0];
    end else if (alu_upd_i.external_data_pointer_inc) begin
      {next_s.data_pointer_high, next_s.data_pointer_low} = 16'(external_data_pointer_now + 16'h0001);
    end

    // parity always follows the accumulator
    next_s.processor_flags_word[PSW_P] = ^next_s.accumulator_reg;

    if (pc_ctl_i.irq_take) begin
      next_s.instruction_pointer = 16'(VEC_BASE + {10'h000, pc_ctl_i.irq_src, 3'b000});
    end else if (pc_ctl_i.load) begin
      next_s.instruction_pointer = pc_ctl_i.target;
    end else if (pc_ctl_i.inc) begin
      next_s.instruction_pointer = 16'(s.instruction_pointer + 16'h0001);
    end

    // update level comes from the programming side: two-flop synchroniser first
    next_s.flash_sync_a = flash_update_i;
    next_s.flash_sync_b = s.flash_sync_a;
    // flash writable and data-mapped only while updating
    next_s.flash_write_en = s.flash_sync_b;
    next_s.flash_in_data = s.flash_sync_b;

    next_s.rd_data = rdata;
    next_s.rd_valid = rvalid;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.stack_top_pointer <= SP_RESET;
      s.instruction_pointer <= PC_RESET;
      s.dram_en <= DRAM_EN_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign rd_valid_o = s.rd_valid;
  assign fetch_addr_o = s.instruction_pointer;
  assign acc_b_pair_o = {s.multiply_partner_reg, s.accumulator_reg};
  assign flags_o = s.processor_flags_word;
  assign stack_top_pointer_o = s.stack_top_pointer;
  assign external_data_pointer_o = {s.data_pointer_high, s.data_pointer_low};
  assign xbus_o = s.xbus;
  assign flash_page_o = s.flash_page;
  assign flash_write_en_o = s.flash_write_en;
  assign flash_in_data_o = s.flash_in_data;

endmodule : mmc_core_memory_map

// [logic/mmc_pkg.sv]
package mmc_pkg;

  localparam int unsigned IRAM_BYTES = 256;
  localparam int unsigned DRAM_BYTES = 256;
  localparam int unsigned SPACE_BYTES = 65536;

  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic DRAM_EN_RESET = 1'b1;

  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] DRAM_PAGE = 8'hff;
  localparam logic [15:0] VEC_BASE = 16'h0003;

  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_FLASH_PAGE = 8'h9a;
  localparam logic [7:0] SFR_DRAM_PTR = 8'h9b;
  localparam logic [7:0] SFR_DRAM_BUF = 8'h9c;
  localparam logic [7:0] SFR_DRAM_CTL = 8'h9d;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;

  localparam int unsigned PSW_CY = 7;
  localparam int unsigned PSW_AC = 6;
  localparam int unsigned PSW_RS1 = 4;
  localparam int unsigned PSW_RS0 = 3;
  localparam int unsigned PSW_OV = 2;
  localparam int unsigned PSW_P = 0;
  localparam int unsigned DRAM_CTL_EN = 0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmc_byte_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] idx;
    logic [7:0] wdata;
  } mmc_reg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic wbit;
  } mmc_bit_req_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] wdata;
  } mmc_stack_req_t;

  typedef struct packed {
    logic acc_we;
    logic [7:0] acc;
    logic b_we;
    logic [7:0] b;
    logic cy_we;
    logic cy;
    logic ac_we;
    logic ac;
    logic ov_we;
    logic ov;
    logic external_data_pointer_we;
    logic [15:0] external_data_pointer;
    logic external_data_pointer_inc;
  } mmc_alu_upd_t;

  typedef struct packed {
    logic inc;
    logic load;
    logic [15:0] target;
    logic irq_take;
    logic [2:0] irq_src;
  } mmc_pc_ctl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic use_external_data_pointer;
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] wdata;
  } mmc_xdata_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmc_xbus_t;

endpackage : mmc_pkg

// [test/mmc_core_memory_map_assertions.sv]
`timescale 1ns/10ps
module mmc_core_memory_map_chk
  import mmc_pkg::*;
(
  input logic sys_clk_i,
  input logic reset_n_i,
  input mmc_byte_req_t direct_req_i,
  input mmc_byte_req_t indirect_req_i,
  input mmc_reg_req_t reg_req_i,
  input mmc_bit_req_t bit_req_i,
  input mmc_stack_req_t stack_req_i,
  input mmc_xdata_req_t xdata_req_i,
  input mmc_alu_upd_t alu_upd_i,
  input mmc_pc_ctl_t pc_ctl_i,
  input logic flash_update_i,
  input logic [7:0] rd_data_o,
  input logic rd_valid_o,
  input logic [15:0] fetch_addr_o,
  input logic [15:0] acc_b_pair_o,
  input logic [7:0] flags_o,
  input logic [7:0] stack_top_pointer_o,
  input logic [15:0] external_data_pointer_o,
  input mmc_xbus_t xbus_o,
  input logic flash_write_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic hi_pri = direct_req_i.valid | indirect_req_i.valid | reg_req_i.valid
    | bit_req_i.valid;
  property p_rst_sp;
    disable iff (1'b0) !reset_n_i |=> stack_top_pointer_o == SP_RESET;
  endproperty
  a_rst_sp: assert property (p_rst_sp) else $error("stack pointer reset");
  property p_rst_pc;
    disable iff (1'b0) !reset_n_i |=> fetch_addr_o == PC_RESET;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("fetch address reset");
  property p_push;
    stack_req_i.push && !hi_pri |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push step");
  property p_vec;
    pc_ctl_i.irq_take |=> fetch_addr_o == VEC_BASE + 16'({$past(pc_ctl_i.irq_src), 3'b000});
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_par;
    flags_o[PSW_P] == ^acc_b_pair_o[7:0];
  endproperty
  a_par: assert property (p_par) else $error("parity");
  property p_pair;
    alu_upd_i.acc_we && alu_upd_i.b_we |=> acc_b_pair_o == $past({alu_upd_i.b, alu_upd_i.acc});
  endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_external_data_pointer;
    alu_upd_i.external_data_pointer_we |=> external_data_pointer_o == $past(alu_upd_i.external_data_pointer);
  endproperty
  a_external_data_pointer: assert property (p_external_data_pointer) else $error("data pointer");
  property p_flash;
    $past(reset_n_i, 1) && $past(reset_n_i, 2) && $past(reset_n_i, 3)
      |-> flash_write_en_o == $past(flash_update_i, 3);
  endproperty
  a_flash: assert property (p_flash) else $error("flash enable");
  property p_sfr_rd;
    direct_req_i.valid && !direct_req_i.write && direct_req_i.addr == SFR_SP
      |=> rd_valid_o && rd_data_o == $past(stack_top_pointer_o);
  endproperty
  a_sfr_rd: assert property (p_sfr_rd) else $error("direct read");
  property p_miss;
    xdata_req_i.valid && !xdata_req_i.use_external_data_pointer && xdata_req_i.high != DRAM_PAGE && !hi_pri
      && !stack_req_i.push && !stack_req_i.pop
      |=> xbus_o.valid && xbus_o.addr == $past({xdata_req_i.high, xdata_req_i.low});
  endproperty
  a_miss: assert property (p_miss) else $error("external pass");
  c_push: cover property (stack_req_i.push);
  c_vec: cover property (pc_ctl_i.irq_take);
  c_xbus: cover property (xbus_o.valid);
endmodule : mmc_core_memory_map_chk

bind mmc_core_memory_map mmc_core_memory_map_chk i_chk (.sys_clk_i, .reset_n_i,
  .direct_req_i, .indirect_req_i, .reg_req_i, .bit_req_i, .stack_req_i, .xdata_req_i,
  .alu_upd_i, .pc_ctl_i, .flash_update_i, .rd_data_o, .rd_valid_o, .fetch_addr_o,
  .acc_b_pair_o, .flags_o, .stack_top_pointer_o, .external_data_pointer_o, .xbus_o,
  .flash_write_en_o);

// [test/mmc_core_memory_map_tb.sv]
`timescale 1ns/10ps
module mmc_core_memory_map_tb
  import mmc_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  mmc_byte_req_t dreq = '0, ireq = '0;
  mmc_reg_req_t rreq = '0;
  mmc_bit_req_t breq = '0;
  mmc_stack_req_t sreq = '0;
  mmc_xdata_req_t xreq = '0;
  mmc_alu_upd_t alu = '0;
  mmc_pc_ctl_t pcc = '0;
  logic fupd = 1'b0;
  logic rd_valid, fl_we, fl_dat;
  logic [7:0] rd_data, sp, flags, d, e, fpage, xh = 8'hff;
  logic [15:0] pc, pair, external_data_pointer;
  logic [2:0] ix;
  mmc_xbus_t xbus;
  logic [7:0] m_ram [256];
  logic [7:0] m_sp = 8'h07;
  logic [31:0] seed = 32'h6c38dd5f;
  int n_fail = 0, num_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;

  mmc_core_memory_map i_mmc_core_memory_map (.sys_clk_i, .reset_n_i, .direct_req_i(dreq),
    .indirect_req_i(ireq), .reg_req_i(rreq), .bit_req_i(breq), .stack_req_i(sreq),
    .xdata_req_i(xreq), .alu_upd_i(alu), .pc_ctl_i(pcc), .flash_update_i(fupd),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .fetch_addr_o(pc), .acc_b_pair_o(pair),
    .flags_o(flags), .stack_top_pointer_o(sp), .external_data_pointer_o(external_data_pointer),
    .xbus_o(xbus), .flash_page_o(fpage), .flash_write_en_o(fl_we), .flash_in_data_o(fl_dat));

  function automatic logic [7:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : lfsr
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] exp);
    chk({7'h00, rd_valid, rd_data}, {8'h01, exp});
  endtask : chk_rd
  task automatic nxt();
    @(posedge sys_clk_i);
    #1;
  endtask : nxt
  task automatic fin();
    nxt();
    {dreq, ireq, rreq, breq, sreq, xreq, alu, pcc} = '0;
  endtask : fin
  task automatic op(input int k, input logic w, input logic [7:0] a, input logic [7:0] v);
    nxt();
    case (k)
      0: dreq = '{1'b1, w, a, v};
      1: ireq = '{1'b1, w, a, v};
      2: rreq = '{1'b1, w, a[2:0], v};
      3: breq = '{1'b1, w, a, v[0]};
      4: sreq = '{w, !w, v};
      default: xreq = '{1'b1, w, 1'b0, xh, a, v};
    endcase
    fin();
  endtask : op

  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end

  initial begin
    foreach (m_ram[i]) m_ram[i] = 8'h00;
    repeat (3) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    chk(16'(sp), 16'h0007);
    chk(pc, 16'h0000);
    op(0, 1'b0, SFR_SP, 8'h00);
    chk_rd(8'h07);
    op(0, 1'b0, 8'h85, 8'h00);
    chk_rd(8'h00);
    repeat (3) begin
      d = lfsr();
      op(4, 1'b1, 8'h00, d);
      m_sp++;
      m_ram[m_sp] = d;
      chk(16'(sp), 16'(m_sp));
    end
    for (int i = 8; i < 11; i++) begin
      op(1, 1'b0, 8'(i), 8'h00);
      chk_rd(m_ram[i]);
    end
    op(4, 1'b0, 8'h00, 8'h00);
    chk_rd(m_ram[m_sp]);
    m_sp--;
    chk(16'(sp), 16'(m_sp));
    d = lfsr();
    e = lfsr();
    op(0, 1'b1, SFR_B, d);
    op(1, 1'b1, SFR_B, e);
    op(0, 1'b0, SFR_B, 8'h00);
    chk_rd(d);
    op(1, 1'b0, SFR_B, 8'h00);
    chk_rd(e);
    chk(pair, {d, 8'h00});
    for (int b = 0; b < 4; b++) begin
      ix = 3'(lfsr());
      d = lfsr();
      op(0, 1'b1, SFR_PSW, 8'(b * 8));
      op(2, 1'b1, {5'h00, ix}, d);
      op(1, 1'b0, 8'(b * 8 + ix), 8'h00);
      chk_rd(d);
      chk(16'(flags[4:3]), 16'(b));
    end
    repeat (2) begin
      d = lfsr() & 8'h7f;
      e = 8'h20 + {4'h0, d[6:3]};
      op(3, 1'b1, d, 8'h01);
      m_ram[e] |= 8'h01 << d[2:0];
      op(0, 1'b0, e, 8'h00);
      chk_rd(m_ram[e]);
      op(3, 1'b0, d, 8'h00);
      chk_rd(8'h01);
    end
    op(3, 1'b1, SFR_ACC + 8'h03, 8'h01);
    chk(16'(pair[7:0]), 16'h0008);
    chk(16'(flags[0]), 16'h0001);
    repeat (4) begin
      d = lfsr();
      e = lfsr();
      ix = 3'(lfsr());
      nxt();
      alu = '{1'b1, d, 1'b1, e, 1'b1, ix[0], 1'b1, ix[1], 1'b1, ix[2], 1'b0, 16'h0000, 1'b0};
      fin();
      chk(pair, {e, d});
      chk(16'({flags[7:6], flags[2]}), 16'({ix[0], ix[1], ix[2]}));
      chk(16'(flags[0]), 16'(^d));
    end
    for (int s = 0; s < 4; s++) begin
      nxt();
      pcc = '{1'b0, 1'b0, 16'h0000, 1'b1, 3'(s)};
      fin();
      chk(pc, 16'h0003 + 16'(s * 8));
    end
    nxt();
    pcc.inc = 1'b1;
    fin();
    chk(pc, 16'h001c);
    d = lfsr();
    e = lfsr();
    nxt();
    pcc.load = 1'b1;
    pcc.target = {d, e};
    fin();
    chk(pc, {d, e});
    nxt();
    pcc = '{1'b0, 1'b1, 16'h1234, 1'b1, 3'h1};
    fin();
    chk(pc, 16'h000b);
    d = lfsr();
    op(0, 1'b1, SFR_FLASH_PAGE, d);
    chk(16'(fpage), 16'(d));
    op(0, 1'b0, SFR_FLASH_PAGE, 8'h00);
    chk_rd(d);
    d = lfsr();
    e = lfsr();
    nxt();
    alu.external_data_pointer_we = 1'b1;
    alu.external_data_pointer = {8'hff, e};
    fin();
    chk(external_data_pointer, {8'hff, e});
    nxt();
    xreq = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00, d};
    fin();
    chk(16'(xbus.valid), 16'h0000);
    op(5, 1'b0, e, 8'h00);
    chk_rd(d);
    op(0, 1'b1, SFR_DRAM_PTR, e);
    d = lfsr();
    op(0, 1'b1, SFR_DRAM_BUF, d);
    op(5, 1'b0, e, 8'h00);
    chk_rd(d);
    op(0, 1'b0, SFR_DRAM_PTR, 8'h00);
    chk_rd(e + 8'h01);
    op(0, 1'b1, SFR_DRAM_CTL, 8'h00);
    op(5, 1'b1, e, d);
    chk({xbus.valid, xbus.addr[14:0]}, {1'b1, 7'h7f, e});
    chk(16'({xbus.write, xbus.wdata}), {7'h00, 1'b1, d});
    xh = 8'h12;
    op(5, 1'b0, e, 8'h00);
    chk(xbus.addr, {8'h12, e});
    nxt();
    fupd = 1'b1;
    repeat (2) nxt();
    chk(16'({fl_we, fl_dat}), 16'h0000);
    nxt();
    chk(16'({fl_we, fl_dat}), 16'h0003);
    fupd = 1'b0;
    repeat (3) nxt();
    chk(16'({fl_we, fl_dat}), 16'h0000);
    nxt();
    alu.external_data_pointer_inc = 1'b1;
    fin();
    chk(external_data_pointer, {8'hff, e} + 16'h0001);
    wrap_up();
  end
endmodule : mmc_core_memory_map_tb
